// ---- logic/descriptor_status_pkg.sv ----
// Purpose: constants and carriers for descriptor status update
// Assumes: 100 MHz core clock, synchronous active-low reset
// Notes: bit positions are within the 64-bit control word and the branch word
`default_nettype none
package descriptor_status_pkg;
    localparam int unsigned ACTIVE_BIT = 63;
    localparam int unsigned HALT_BIT = 62;
    localparam int unsigned BABBLE_BIT = 61;
    localparam int unsigned XERR_BIT = 60;
    localparam int unsigned PING_BIT = 58;
    localparam int unsigned TOGGLE_BIT = 57;
    localparam int unsigned CERR_LO = 55;
    localparam int unsigned NAK_LO = 51;
    localparam int unsigned RELOAD_LO = 25;
    localparam int unsigned VALID_BIT = 0;
    localparam int unsigned JUMP_BIT = 5;
    localparam int unsigned INDEX_LO = 0;
    localparam int unsigned UPPER_OFS = 32;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_RELOAD = 4'h1;
    localparam logic [3:0] ADDR_BRANCH = 4'h2;
    localparam logic [3:0] ADDR_SLOT = 4'h3;
    localparam logic [4:0] SLOT_RESET = 5'h00;
    localparam logic [1:0] CERR_RESET = 2'h0;
    localparam logic [3:0] NAK_RESET = 4'h0;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_NEXT = 2'b11
    } phase_t;

    typedef enum logic [2:0]
    {
        RES_ACK = 3'h0,
        RES_NAK = 3'h1,
        RES_PID_ERR = 3'h2,
        RES_BABBLE = 3'h3,
        RES_STALL = 3'h4
    } result_t;

    typedef struct packed
    {
        logic active;
        logic valid;
        logic halt;
        logic babble;
        logic xerr;
        logic ping;
        logic toggle_bit;
        logic [1:0] cerr;
        logic [3:0] negative_ack_counter;
        logic [3:0] counter_reload_value;
        logic jump;
        logic [4:0] next_descriptor_index;
    } descriptor_t;

    typedef struct packed
    {
        logic done;
        result_t result;
        logic data_packet;
        logic ping_state;
        logic high_speed;
    } outcome_t;

    typedef struct packed
    {
        descriptor_t desc;
        phase_t phase;
        logic [4:0] slot;
        logic [31:0] rdata;
    } state_t;
endpackage
`default_nettype wire

// ---- logic/descriptor_status.sv ----
// Purpose: status and branching update for one bulk/control transfer descriptor
// Assumes: transaction engine reports one outcome pulse per executed transaction
// Notes: registers on plain strobe port, read data one cycle after read strobe
`default_nettype none
module descriptor_status
    import descriptor_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire outcome_t outcome,
    output logic launch,
    output logic [4:0] slot,
    output logic slot_advance
);
    state_t cur;
    state_t next_cur;

    // upper control word bits 63..51 sit at 31..19 of the status word
    function automatic logic [31:0] status_word(input descriptor_t d);
        logic [31:0] w;
        w = '0;
        w[ACTIVE_BIT - UPPER_OFS] = d.active;
        w[HALT_BIT - UPPER_OFS] = d.halt;
        w[BABBLE_BIT - UPPER_OFS] = d.babble;
        w[XERR_BIT - UPPER_OFS] = d.xerr;
        w[PING_BIT - UPPER_OFS] = d.ping;
        w[TOGGLE_BIT - UPPER_OFS] = d.toggle_bit;
        w[CERR_LO - UPPER_OFS +: 2] = d.cerr;
        w[NAK_LO - UPPER_OFS +: 4] = d.negative_ack_counter;
        w[VALID_BIT] = d.valid;
        return w;
    endfunction

    function automatic logic [31:0] reload_word(input descriptor_t d);
        logic [31:0] w;
        w = '0;
        w[RELOAD_LO +: 4] = d.counter_reload_value;
        return w;
    endfunction

    function automatic logic [31:0] branch_word(input descriptor_t d);
        logic [31:0] w;
        w = '0;
        w[JUMP_BIT] = d.jump;
        w[INDEX_LO +: 5] = d.next_descriptor_index;
        return w;
    endfunction

    function automatic logic [31:0] slot_word(input logic [4:0] s);
        logic [31:0] w;
        w = '0;
        w[INDEX_LO +: 5] = s;
        return w;
    endfunction

    // unmapped offsets read as zero
    function automatic logic [31:0] read_word(input state_t s, input logic [3:0] a);
        logic [31:0] w;
        w = '0;
        case (a)
            ADDR_STATUS: w = status_word(s.desc);
            ADDR_RELOAD: w = reload_word(s.desc);
            ADDR_BRANCH: w = branch_word(s.desc);
            ADDR_SLOT: w = slot_word(s.slot);
            default: w = '0;
        endcase
        return w;
    endfunction

    // a status write relaunches: sticky error flags start clear
    function automatic descriptor_t write_status(input descriptor_t d, input logic [31:0] w);
        descriptor_t n;
        n = d;
        n.active = w[ACTIVE_BIT - UPPER_OFS];
        n.valid = w[VALID_BIT];
        n.ping = w[PING_BIT - UPPER_OFS];
        n.toggle_bit = w[TOGGLE_BIT - UPPER_OFS];
        n.cerr = w[CERR_LO - UPPER_OFS +: 2];
        n.negative_ack_counter = w[NAK_LO - UPPER_OFS +: 4];
        n.halt = 1'b0;
        n.babble = 1'b0;
        n.xerr = 1'b0;
        return n;
    endfunction

    function automatic descriptor_t write_reload(input descriptor_t d, input logic [31:0] w);
        descriptor_t n;
        n = d;
        n.counter_reload_value = w[RELOAD_LO +: 4];
        return n;
    endfunction

    function automatic descriptor_t write_branch(input descriptor_t d, input logic [31:0] w);
        descriptor_t n;
        n = d;
        n.jump = w[JUMP_BIT];
        n.next_descriptor_index = w[INDEX_LO +: 5];
        return n;
    endfunction

    // unmapped offsets ignore writes
    function automatic state_t apply_write(input state_t s, input logic [3:0] a, input logic [31:0] w);
        state_t n;
        n = s;
        case (a)
            ADDR_STATUS: n.desc = write_status(s.desc, w);
            ADDR_RELOAD: n.desc = write_reload(s.desc, w);
            ADDR_BRANCH: n.desc = write_branch(s.desc, w);
            ADDR_SLOT: n.slot = w[INDEX_LO +: 5];
            default: n = s;
        endcase
        return n;
    endfunction

    function automatic logic can_start(input descriptor_t d);
        return d.active && d.valid;
    endfunction

    // ends processing; valid survives only a halt
    function automatic descriptor_t retire(input descriptor_t d, input logic keep_valid);
        descriptor_t n;
        n = d;
        n.active = 1'b0;
        if (!keep_valid)
        begin
            n.valid = 1'b0;
        end
        return n;
    endfunction

    // zero reload switches nak counting off
    function automatic logic nak_counting(input descriptor_t d);
        return d.counter_reload_value != NAK_RESET;
    endfunction

    function automatic logic nak_expires(input descriptor_t d);
        return d.negative_ack_counter <= 4'h1;
    endfunction

    // 00 and 01 both flag the error at once
    function automatic logic retries_spent(input descriptor_t d);
        return d.cerr <= 2'h1;
    endfunction

    // base carries same-cycle writes, d the registered fields that decide
    function automatic descriptor_t on_ack(input descriptor_t base, input descriptor_t d, input logic data_packet);
        descriptor_t n;
        n = base;
        n.negative_ack_counter = d.counter_reload_value;
        if (data_packet)
        begin
            n.toggle_bit = ~d.toggle_bit;
        end
        return n;
    endfunction

    function automatic descriptor_t on_nak(input descriptor_t base, input descriptor_t d);
        descriptor_t n;
        n = base;
        if (nak_counting(d))
        begin
            n.negative_ack_counter = d.negative_ack_counter - 4'h1;
            if (nak_expires(d))
            begin
                n = retire(n, 1'b0);
                n.negative_ack_counter = NAK_RESET;
            end
        end
        return n;
    endfunction

    function automatic descriptor_t on_pid_error(input descriptor_t base, input descriptor_t d);
        descriptor_t n;
        n = base;
        if (retries_spent(d))
        begin
            n = retire(n, 1'b0);
            n.cerr = CERR_RESET;
            n.xerr = 1'b1;
        end
        else
        begin
            n.cerr = d.cerr - 2'h1;
        end
        return n;
    endfunction

    function automatic descriptor_t apply_outcome(input descriptor_t base, input descriptor_t d, input outcome_t o);
        descriptor_t n;
        n = base;
        if (o.high_speed)
        begin
            n.ping = o.ping_state;
        end
        case (o.result)
            RES_ACK: n = on_ack(n, d, o.data_packet);
            RES_NAK: n = on_nak(n, d);
            RES_PID_ERR: n = on_pid_error(n, d);
            RES_BABBLE:
            begin
                n = retire(n, 1'b0);
                n.babble = 1'b1;
            end
            RES_STALL:
            begin
                n = retire(n, 1'b1);
                n.halt = 1'b1;
            end
            default: n = base;
        endcase
        return n;
    endfunction

    // results after which this descriptor is finished
    function automatic logic ends_here(input descriptor_t d, input result_t r);
        logic e;
        e = 1'b0;
        case (r)
            RES_ACK: e = 1'b0;
            RES_NAK: e = nak_counting(d) && nak_expires(d);
            RES_PID_ERR: e = retries_spent(d);
            RES_BABBLE: e = 1'b1;
            RES_STALL: e = 1'b1;
            default: e = 1'b0;
        endcase
        return e;
    endfunction

    function automatic logic [4:0] follow_slot(input descriptor_t d, input logic [4:0] s);
        logic [4:0] n;
        n = s + 5'h01;
        if (d.jump)
        begin
            n = d.next_descriptor_index;
        end
        return n;
    endfunction

    // bus access first; a same-cycle outcome overrides the written fields
    always_comb
    begin
        next_cur = cur;
        next_cur.rdata = '0;
        if (rd)
        begin
            next_cur.rdata = read_word(cur, addr);
        end
        if (wr)
        begin
            next_cur = apply_write(next_cur, addr, wdata);
        end
        case (cur.phase)
            ST_IDLE:
            begin
                // no launch while software is still writing
                if (can_start(cur.desc) && !wr)
                begin
                    next_cur.phase = ST_BUSY;
                end
            end
            ST_BUSY:
            begin
                if (!cur.desc.active)
                begin
                    next_cur.phase = ST_NEXT;
                end
                else if (outcome.done)
                begin
                    next_cur.desc = apply_outcome(next_cur.desc, cur.desc, outcome);
                    if (ends_here(cur.desc, outcome.result))
                    begin
                        next_cur.phase = ST_NEXT;
                    end
                end
            end
            ST_NEXT:
            begin
                next_cur.slot = follow_slot(cur.desc, cur.slot);
                next_cur.phase = ST_IDLE;
            end
            default: next_cur.phase = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cur <= '0;
            cur.slot <= SLOT_RESET;
            cur.phase <= ST_IDLE;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign rdata = cur.rdata;
    assign slot = cur.slot;
    assign launch = (cur.phase == ST_BUSY) && cur.desc.active;
    assign slot_advance = (cur.phase == ST_NEXT);
endmodule // descriptor_status
`default_nettype wire

// ---- bench/descriptor_status_checker.sv ----
// Purpose: port assertions for descriptor_status
// Assumes: one clock, synchronous active-low reset
// Notes: branch word shadowed from bus writes
`default_nettype none
module descriptor_status_checker
    import descriptor_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire outcome_t outcome,
    input wire logic launch,
    input wire logic [4:0] slot,
    input wire logic slot_advance
);
    timeunit 1ns;
    timeprecision 1ps;
    logic jmp;
    logic [4:0] idx;
    always_ff @(posedge clk)
    begin
        if (!rst_n) {jmp, idx} <= 6'h00;
        else if (wr && addr == ADDR_BRANCH) {jmp, idx} <= wdata[5:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    property p_unmapped; rd && addr > ADDR_SLOT |=> rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_adv_pulse; slot_advance |=> !slot_advance; endproperty
    a_adv_pulse: assert property (p_adv_pulse) else $error("slot advance longer than one cycle");
    property p_slot_hold; !slot_advance && !(wr && addr == ADDR_SLOT) |=> $stable(slot); endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("slot moved without advance");
    property p_branch; slot_advance && jmp |=> slot == idx; endproperty
    a_branch: assert property (p_branch) else $error("branch slot wrong");
    property p_step; slot_advance && !jmp |=> slot == $past(slot) + 5'h01; endproperty
    a_step: assert property (p_step) else $error("step slot wrong");
    property p_babble; launch && outcome.done && outcome.result == RES_BABBLE |=> !launch ##[0:2] slot_advance; endproperty
    a_babble: assert property (p_babble) else $error("babble did not retire");
    property p_stall; launch && outcome.done && outcome.result == RES_STALL |=> !launch; endproperty
    a_stall: assert property (p_stall) else $error("halt did not stop");
    property p_skip; wr && addr == ADDR_STATUS && !wdata[31] |=> !launch; endproperty
    a_skip: assert property (p_skip) else $error("inactive descriptor still launched");
    c_branch: cover property (slot_advance && jmp);
    c_babble: cover property (launch && outcome.done && outcome.result == RES_BABBLE);
    c_skip: cover property (wr && addr == ADDR_STATUS && launch);
endmodule // descriptor_status_checker
bind descriptor_status descriptor_status_checker chk_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .outcome(outcome), .launch(launch), .slot(slot), .slot_advance(slot_advance));
`default_nettype wire

// ---- bench/engine_model.sv ----
// Purpose: transaction engine stand-in
// Assumes: one outcome per fire, given only while launch is high
// Notes: idle flag fields toggle so stale values never match
`default_nettype none
module engine_model
    import descriptor_status_pkg::*;
(
    input wire logic clk,
    input wire logic launch,
    input wire logic fire,
    input wire result_t res,
    input wire logic dp,
    output var outcome_t outcome
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend = 1'b0;
    logic junk = 1'b0;
    always @(posedge clk)
    begin
        junk <= !junk;
        if (fire) pend <= 1'b1;
        if (pend && launch && !outcome.done)
        begin
            pend <= 1'b0;
            outcome <= {1'b1, res, dp, dp, 1'b1};
        end
        else outcome <= {1'b0, res, junk, junk, junk};
    end
endmodule // engine_model
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: self-checking bench for descriptor_status
// Assumes: engine_model answers each fire
// Notes: rows launch one descriptor and check the status word
`default_nettype none
module tb import descriptor_status_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: %h", $time, g); end end
    typedef struct packed {logic [1:0] c; logic [3:0] rl; result_t res; logic dp; logic [31:0] e; logic [31:0] m;} row_t;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, fire = 1'b0, dp = 1'b0, launch, adv;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, v, rdata;
    logic [4:0] slot;
    result_t res = RES_ACK;
    outcome_t outcome;
    int n_fail = 0, tests_run = 0;
    row_t rows [8];
    function automatic logic [31:0] st(logic [3:0] f, logic p, logic t, logic [1:0] c, logic [3:0] n, logic vb);
        return {f, 1'b0, p, t, c, n, 18'h0, vb};
    endfunction
    initial forever #5 clk = !clk;
    descriptor_status dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .outcome(outcome), .launch(launch), .slot(slot), .slot_advance(adv));
    engine_model eng_u (.clk(clk), .launch(launch), .fire(fire), .res(res), .dp(dp), .outcome(outcome));
    task automatic bw(logic [3:0] a, logic [31:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task automatic br(logic [3:0] a, output logic [31:0] d);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0; #1 d = rdata;
    endtask
    task automatic shot(result_t r, logic p);
        @(posedge clk); fire <= 1'b1; res <= r; dp <= p;
        @(posedge clk); fire <= 1'b0;
        #1;
        for (int k = 0; k < 20 && outcome.done !== 1'b1; k++) @(posedge clk) #1;
        repeat (4) @(posedge clk);
        br(ADDR_STATUS, v);
    endtask
    task automatic go(row_t r);
        bw(ADDR_RELOAD, {3'h0, r.rl, 25'h0});
        bw(ADDR_STATUS, st(4'h8, 1'b0, 1'b0, r.c, r.rl, 1'b1));
        shot(r.res, r.dp);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        finish_test;
    end
    initial
    begin
        rows = '{'{2'h3, 4'h5, RES_ACK, 1'b1, st(4'h8, 1, 1, 2'h3, 4'h5, 1), '1},
            '{2'h3, 4'h3, RES_NAK, 1'b0, st(4'h8, 0, 0, 2'h3, 4'h2, 1), '1},
            '{2'h3, 4'h1, RES_NAK, 1'b0, st(4'h0, 0, 0, 2'h3, 4'h0, 0), '1},
            '{2'h3, 4'h0, RES_NAK, 1'b0, st(4'h8, 0, 0, 2'h3, 4'h0, 1), '1},
            '{2'h3, 4'h0, RES_PID_ERR, 1'b0, st(4'h8, 0, 0, 2'h2, 4'h0, 1), '1},
            '{2'h0, 4'h0, RES_PID_ERR, 1'b0, st(4'h1, 0, 0, 2'h0, 4'h0, 0), ~32'h0180_0000},
            '{2'h3, 4'h0, RES_BABBLE, 1'b0, st(4'h2, 0, 0, 2'h3, 4'h0, 0), '1},
            '{2'h3, 4'h0, RES_STALL, 1'b0, st(4'h4, 0, 0, 2'h3, 4'h0, 0), ~32'h1}};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            go(rows[i]);
            `CHK(v & rows[i].m, rows[i].e & rows[i].m)
            bw(ADDR_STATUS, 32'h0);
            $display("row %0d done", i);
        end
        bw(ADDR_BRANCH, 32'h0000_003A);
        go(rows[6]);
        br(ADDR_SLOT, v);
        `CHK(v, 32'h0000_001A)
        bw(ADDR_BRANCH, 32'h0);
        go(rows[6]);
        br(ADDR_SLOT, v);
        `CHK(v, 32'h0000_001B)
        $display("branch test done");
        go(rows[1]);
        shot(RES_ACK, 1'b1);
        `CHK(v, st(4'h8, 1, 1, 2'h3, 4'h3, 1))
        bw(ADDR_STATUS, v);
        br(ADDR_STATUS, v);
        `CHK(v, st(4'h8, 1, 1, 2'h3, 4'h3, 1))
        bw(ADDR_STATUS, 32'h0);
        bw(4'hF, 32'hFFFF_FFFF);
        br(4'hF, v);
        `CHK(v, 32'h0)
        $display("reload test done");
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        br(ADDR_SLOT, v);
        `CHK(v, 32'h0)
        br(ADDR_BRANCH, v);
        `CHK(v, 32'h0)
        $display("reset test done");
        finish_test;
    end
endmodule // tb
`default_nettype wire
